// [logic/pit_timer.sv]
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pit_timer
	import pit_pkg::*;
#(
	parameter logic [COUNT_W-1:0] STAB_START = 8'h00
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  wake_event,
	output logic                       system_clock,
	output logic      [PRESCALE_W-1:0] peripheral_taps,
	output logic                       watchdog_tick,
	output logic                       osc_enable,
	output logic                       core_run,
	output logic                       irq
);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// state
	// ****************************************************************
	pit_mode_e             mode;
	pit_mode_e             next_mode;
	pit_ctrl_s             ctrl;
	pit_ctrl_s             next_ctrl;
	logic [1:0]            clear_cnt;
	logic [1:0]            next_clear_cnt;
	logic [COUNT_W-1:0]    count;
	logic [COUNT_W-1:0]    next_count;
	logic [1:0]            irq_status;
	logic [1:0]            next_irq_status;
	logic [1:0]            irq_mask;
	logic [1:0]            next_irq_mask;
	logic [PRESCALE_W-1:0] pre_cnt;
	logic                  tap_edge;
	logic                  overflow;
	logic                  access;
	logic                  wr;
	logic                  wr_count;
	logic                  wr_mode;
	logic [31:0]           next_prdata;
	logic                  next_pslverr;
	logic                  mapped;

	pit_prescaler u_prescaler (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (mode != PIT_STOP), // see (R6)
		.sel      (ctrl.sel),
		.cnt      (pre_cnt),
		.tap_edge (tap_edge)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign access   = psel & penable & ~pready;
	assign wr       = psel & penable & pready & pwrite;
	assign wr_count = wr & (paddr == ADDR_COUNT); // see (R13)
	assign wr_mode  = wr & (paddr == ADDR_MODE) & pwdata[MODE_ENTER_STOP];
	assign overflow = tap_edge & (count == 8'hFF) & ~ctrl.clear & (mode != PIT_STOP); // see (R8)

	always_comb begin
		mapped       = 1'b1;
		next_prdata  = '0;
		case (paddr)
			ADDR_COUNT: begin
				next_prdata[COUNT_W-1:0] = count; // see (R13)
			end
			ADDR_CTRL: begin
				next_prdata[CTRL_PERIPH_EN_BIT]      = ctrl.periph_en;
				next_prdata[CTRL_CLEAR_BIT]          = ctrl.clear;
				next_prdata[CTRL_SEL_LSB +: 3]       = ctrl.sel;
			end
			ADDR_IRQ_STATUS: begin
				next_prdata[1:0] = irq_status;
			end
			ADDR_IRQ_MASK: begin
				next_prdata[1:0] = irq_mask;
			end
			ADDR_MODE: begin
				next_prdata[MODE_STAB_BIT] = (mode == PIT_STAB);
				next_prdata[MODE_STOP_BIT] = (mode == PIT_STOP);
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (!access || pwrite) begin
			next_prdata = prdata;
		end
		next_pslverr = access & ~mapped;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// operating mode
	// ****************************************************************
	always_comb begin
		next_mode = mode;
		case (mode)
			PIT_STAB: begin
				if (overflow) begin
					next_mode = PIT_RUN; // see (R12) (R5)
				end
			end
			PIT_RUN: begin
				if (wr_mode) begin
					next_mode = PIT_STOP;
				end
			end
			PIT_STOP: begin
				if (wake_event) begin
					next_mode = PIT_STAB; // see (R12)
				end
			end
			default: begin
				next_mode = PIT_STAB;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode         <= PIT_STAB;
			system_clock <= 1'b0;
			osc_enable   <= 1'b1;
			core_run     <= 1'b0;
		end else begin
			mode         <= next_mode;
			system_clock <= (mode != PIT_STOP) ? ~system_clock : system_clock; // see (R1) (R6)
			osc_enable   <= (next_mode != PIT_STOP); // see (R6)
			core_run     <= (next_mode == PIT_RUN); // see (R5)
		end
	end

	// ****************************************************************
	// control register and interval counter
	// ****************************************************************
	always_comb begin
		next_ctrl      = ctrl;
		next_clear_cnt = clear_cnt;
		if (ctrl.clear && mode != PIT_STOP) begin
			if (clear_cnt == CLEAR_LAST) begin
				next_ctrl.clear = 1'b0; // see (R9)
			end else begin
				next_clear_cnt = clear_cnt + 2'h1;
			end
		end
		if (wr_count) begin
			next_ctrl.periph_en = pwdata[CTRL_PERIPH_EN_BIT]; // see (R4)
			next_ctrl.sel       = pwdata[CTRL_SEL_LSB +: 3]; // see (R10)
			if (pwdata[CTRL_CLEAR_BIT]) begin
				next_ctrl.clear = 1'b1; // see (R9)
				next_clear_cnt  = 2'h0;
			end
		end
	end

	always_comb begin
		next_count = count;
		if (mode == PIT_STOP) begin
			if (wake_event) begin
				next_count = STAB_START; // see (R12)
			end
		end else if (ctrl.clear) begin
			next_count = '0; // see (R9)
		end else if (tap_edge) begin
			next_count = count + 8'h01; // see (R7) (R15)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl.periph_en <= PERIPH_EN_RESET; // see (R4)
			ctrl.clear     <= CLEAR_RESET;
			ctrl.sel       <= SEL_RESET; // see (R11)
			clear_cnt      <= 2'h0;
			count          <= STAB_START;
		end else begin
			ctrl      <= next_ctrl;
			clear_cnt <= next_clear_cnt;
			count     <= next_count;
		end
	end

	// ****************************************************************
	// peripheral clocks, watchdog, interrupts
	// ****************************************************************
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (wr && paddr == ADDR_IRQ_STATUS) begin
			next_irq_status = irq_status & ~pwdata[1:0];
		end
		if (wr && paddr == ADDR_IRQ_MASK) begin
			next_irq_mask = pwdata[1:0];
		end
		next_irq_status[IRQ_OVERFLOW_BIT]  = next_irq_status[IRQ_OVERFLOW_BIT] | overflow; // see (R8)
		next_irq_status[IRQ_STAB_DONE_BIT] = next_irq_status[IRQ_STAB_DONE_BIT] | (overflow && mode == PIT_STAB);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status      <= 2'h0;
			irq_mask        <= IRQ_MASK_RESET;
			irq             <= 1'b0;
			watchdog_tick   <= 1'b0;
			peripheral_taps <= '0;
		end else begin
			irq_status      <= next_irq_status;
			irq_mask        <= next_irq_mask;
			irq             <= |(next_irq_status & next_irq_mask);
			watchdog_tick   <= overflow; // see (R14)
			peripheral_taps <= ctrl.periph_en ? pre_cnt : peripheral_taps; // see (R3) (R4)
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	logic ctrl_written;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_written <= 1'b0;
		end else begin
			ctrl_written <= ctrl_written | wr_count;
		end
	end

	sel_reset_a: assert property (!ctrl_written |-> ctrl.sel == 3'h7 && ctrl.periph_en) // see (R11)
		else $error("control not at reset value");

	tick_count_a: assert property ((tap_edge && mode != PIT_STOP && !ctrl.clear) // see (R15)
		|=> count == $past(count) + 8'h01)
		else $error("interval counter missed a tap edge");

	wrap_flag_a: assert property (overflow |=> irq_status[IRQ_OVERFLOW_BIT] && count == 8'h00) // see (R8)
		else $error("wrap did not set the flag");

	clear_pulse_a: assert property ($rose(ctrl.clear) && !wr_count |-> ctrl.clear [*2] ##1 !ctrl.clear) // see (R9)
		else $error("clear bit did not self-clear after one machine cycle");

	clear_zero_a: assert property (ctrl.clear && mode != PIT_STOP |=> count == 8'h00) // see (R9)
		else $error("counter not cleared");

	stop_freeze_a: assert property (mode == PIT_STOP && !wake_event // see (R6)
		|=> $stable(count) && $stable(system_clock) && !osc_enable)
		else $error("state moved during stop");

	stab_end_a: assert property (mode == PIT_STAB && overflow |=> mode == PIT_RUN ##1 core_run) // see (R12)
		else $error("stabilisation did not end on wrap");

	sys_div_a: assert property (mode != PIT_STOP |=> system_clock != $past(system_clock)) // see (R1)
		else $error("system clock not toggling");

	gate_hold_a: assert property (!ctrl.periph_en |=> $stable(peripheral_taps)) // see (R4)
		else $error("peripheral clock ran while gated");

	wdt_clock_a: assert property (overflow |=> watchdog_tick ##1 !watchdog_tick) // see (R14)
		else $error("watchdog tick missing");

	read_live_a: assert property (access && !pwrite && paddr == ADDR_COUNT // see (R13)
		|=> pready && prdata == {24'h00_0000, $past(count)})
		else $error("count read wrong");

endmodule // pit_timer
`default_nettype wire

// [logic/pit_pkg.sv]
// Operation
// (R1) System clock is oscillator divided by two
// (R2) Prescaler is 12-bit counter on oscillator clock
// (R3) Each prescaler bit drives a divided peripheral tap
// (R4) Control bit 4 gates peripheral clock, resets 1
// (R5) Reset release enters main-clock operating mode
// (R6) STOP halts everything, keeps all state intact
// (R7) Free-running 8-bit interval counter, halted only in STOP
// (R8) Interval counter wrap FF to 00 sets flag
// (R9) Control bit 3 clears counter, self-clears later
// (R10) Three-bit select picks tap, 2us to 256us; code gives 32ns to 4096ns at its 4ns OSC_PERIOD_PS
// (R11) Any reset forces select field to ones
// (R12) Interval counter times oscillator stabilisation
// (R13) Count address reads counter, writes control
// (R14) Interval counter clocks the watchdog timer
// (R15) Count on selected tap rising edge, synchronously
package pit_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ADDR_COUNT      = 8'h00;
	localparam logic [7:0] ADDR_CTRL       = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0C;
	localparam logic [7:0] ADDR_MODE       = 8'h10;

	// ****************************************************************
	// field layout and reset values
	// ****************************************************************
	localparam int         CTRL_PERIPH_EN_BIT = 4;
	localparam int         CTRL_CLEAR_BIT     = 3;
	localparam int         CTRL_SEL_LSB       = 0;
	localparam logic       PERIPH_EN_RESET    = 1'b1;
	localparam logic       CLEAR_RESET        = 1'b0;
	localparam logic [2:0] SEL_RESET          = 3'h7;
	localparam int         IRQ_OVERFLOW_BIT   = 0;
	localparam int         IRQ_STAB_DONE_BIT  = 1;
	localparam int         MODE_STAB_BIT      = 0;
	localparam int         MODE_STOP_BIT      = 1;
	localparam int         MODE_ENTER_STOP    = 0;
	localparam logic [1:0] IRQ_MASK_RESET     = 2'h0;

	// ****************************************************************
	// widths and timing
	// ****************************************************************
	localparam int         PRESCALE_W         = 12;
	localparam int         COUNT_W            = 8;
	localparam int         TAP_BASE           = 2;
	localparam int         OSC_PERIOD_PS      = 4000;
	localparam int         MACHINE_CYCLE_PS   = 8000;
	localparam int         MACHINE_CYCLE_CLKS = (MACHINE_CYCLE_PS + OSC_PERIOD_PS - 1) / OSC_PERIOD_PS;
	localparam logic [1:0] CLEAR_LAST         = 2'(MACHINE_CYCLE_CLKS - 1);

	typedef enum logic [1:0] {
		PIT_STAB,
		PIT_RUN,
		PIT_STOP
	} pit_mode_e;

	typedef struct packed {
		logic       periph_en;
		logic       clear;
		logic [2:0] sel;
	} pit_ctrl_s;

	// prescaler bit that drives the interval counter for a select code
	function automatic logic tap_bit(input logic [PRESCALE_W-1:0] cnt, input logic [2:0] sel);
		tap_bit = cnt[TAP_BASE + int'(sel)];
	endfunction

endpackage

// [logic/pit_prescaler.sv]
`timescale 1ns/100ps
`default_nettype none
module pit_prescaler
	import pit_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  run,
	input  wire logic [2:0]            sel,
	output logic      [PRESCALE_W-1:0] cnt,
	output logic                       tap_edge
);

	// ****************************************************************
	// divider chain
	// ****************************************************************
	logic [PRESCALE_W-1:0] next_cnt;
	logic                  next_tap_edge;

	always_comb begin
		next_cnt      = cnt;
		next_tap_edge = 1'b0;
		if (run) begin
			next_cnt      = cnt + 12'h001; // see (R2)
			next_tap_edge = tap_bit(next_cnt, sel) & ~tap_bit(cnt, sel); // see (R15) (R10)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt      <= '0;
			tap_edge <= 1'b0;
		end else begin
			cnt      <= next_cnt;
			tap_edge <= next_tap_edge;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	count_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see (R2)
		run |=> cnt == $past(cnt) + 12'h001)
		else $error("prescaler did not advance");

	stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see (R6)
		!run |=> $stable(cnt) && !tap_edge)
		else $error("prescaler moved while halted");

endmodule // pit_prescaler
`default_nettype wire

// [testbench/pit_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// core side: counts watchdog ticks, raises wake on request
// ****************************************************************
module pit_far_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        watchdog_tick,
	input  wire logic        wake_req,
	output logic             wake_event,
	output logic      [15:0] tick_count
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_event <= 1'b0;
			tick_count <= 16'h0000;
		end else begin
			wake_event <= wake_req;
			if (watchdog_tick) begin
				tick_count <= tick_count + 16'h0001;
			end
		end
	end
endmodule // pit_far_model
`default_nettype wire

// [testbench/prescaler_interval_timer_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module prescaler_interval_timer_bench;
	import pit_pkg::*;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic                  wake_req = 1'b0;
	logic [7:0]            paddr = 8'h00;
	logic [31:0]           pwdata = 32'h0000_0000;
	logic [31:0]           prdata, rd, rd2;
	logic                  pready, pslverr, er, wake_event, sc0;
	logic                  system_clock, watchdog_tick, osc_enable, core_run, irq;
	logic [PRESCALE_W-1:0] peripheral_taps, taps0;
	logic [15:0]           tick_count;
	int                    n_errors = 0;
	int                    checks_done = 0;
	int                    n;

	pit_timer #(.STAB_START(8'hFE)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wake_event(wake_event), .system_clock(system_clock), .peripheral_taps(peripheral_taps),
		.watchdog_tick(watchdog_tick), .osc_enable(osc_enable), .core_run(core_run), .irq(irq)
	);
	pit_far_model i_far (
		.pclk(pclk), .presetn(presetn), .watchdog_tick(watchdog_tick),
		.wake_req(wake_req), .wake_event(wake_event), .tick_count(tick_count)
	);

	always #2 pclk = ~pclk;

	// ****************************************************************
	// bus cycles and comparisons
	// ****************************************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (pready !== 1'b1) begin
			n_errors++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: got %h range %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wait_on(input bit for_run);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (((for_run ? core_run : watchdog_tick) !== 1'b1) && n < 5000);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#80000;
		n_errors++;
		wrap_up();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, ADDR_CTRL, 0);      check_eq(rd, 32'h0000_0017);
		apb(0, ADDR_IRQ_MASK, 0);  check_eq(rd, 32'h0000_0000);
		apb(0, ADDR_MODE, 0);      check_eq(rd, 32'h0000_0001);
		wait_on(1);                check_in(n, 1000, 2100);
		apb(0, ADDR_MODE, 0);      check_eq(rd, 32'h0000_0000);
		apb(0, ADDR_IRQ_STATUS, 0); check_eq(rd, 32'h0000_0003);
		apb(1, ADDR_IRQ_MASK, 1);
		#1;
		check_eq(irq, 1'b1);
		apb(1, ADDR_IRQ_STATUS, 3); @(posedge pclk);
		check_eq(irq, 1'b0);
		#1;
		sc0 = system_clock;
		taps0 = peripheral_taps;
		@(posedge pclk); #1;
		check_eq(system_clock, !sc0);
		check_eq(peripheral_taps[0], !taps0[0]);
		// clear with fastest tap, time one full wrap
		apb(1, ADDR_COUNT, 32'h0000_0018);
		wait_on(0);                check_in(n, 2038, 2058);
		@(posedge pclk); #1;
		check_eq(irq, 1'b1);
		check_eq(tick_count, 32'h0000_0002);
		apb(0, ADDR_COUNT, 0);
		rd2 = rd;
		repeat (80) @(posedge pclk);
		apb(0, ADDR_COUNT, 0);     check_in(rd - rd2, 9, 12);
		apb(1, ADDR_CTRL, 0);
		apb(0, ADDR_CTRL, 0);      check_eq(rd, 32'h0000_0010);
		apb(0, 8'h20, 0);          check_eq({er, rd[30:0]}, 32'h8000_0000);
		apb(1, ADDR_COUNT, 32'h0000_0000);
		#1;
		taps0 = peripheral_taps;
		repeat (20) @(posedge pclk);
		check_eq(peripheral_taps, taps0);
		apb(1, ADDR_COUNT, 32'h0000_0010);
		apb(1, ADDR_MODE, 32'h0000_0001);
		repeat (4) @(posedge pclk);
		check_eq({osc_enable, core_run}, 2'b00);
		taps0 = peripheral_taps;
		sc0 = system_clock;
		repeat (40) @(posedge pclk);
		check_eq({system_clock, peripheral_taps}, {sc0, taps0});
		apb(0, ADDR_MODE, 0);      check_eq(rd, 32'h0000_0002);
		wake_req <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
		wait_on(1);                check_in(n, 1, 300);
		check_eq(osc_enable, 1'b1);
		wrap_up();
	end
endmodule // prescaler_interval_timer_bench
`default_nettype wire
